// ==== i2cmp_consts.vh ====
// Shared constants for the six-port two-wire bus controller.
`ifndef I2CMP_CONSTS_VH
`define I2CMP_CONSTS_VH
`define I2CMP_NPORTS 6
`define I2CMP_MS_PORTS 2
`define I2CMP_DIV_W 16
`define I2CMP_ADDR_W 7
`define I2CMP_NSADDR 3
`define I2CMP_SADDR_W 21
`define I2CMP_GLITCH_CYC 3'h4
`define I2CMP_LINE_IDLE 1'b1
`define I2CMP_BIT_FIRST 4'h8
`define I2CMP_ACK_BIT 4'h0
`define I2CMP_SCNT_FULL 4'h8
`define I2CMP_DIR_BIT 0
`define I2CMP_TEN_PFX 5'h1e
`define I2CMP_STEP_0 2'h0
`define I2CMP_STEP_1 2'h1
`define I2CMP_STEP_2 2'h2
`endif

// ==== i2cmp_filt.v ====
// Two-flop synchroniser and four-cycle glitch filter for one bus line.
`timescale 1ns/10ps
`include "i2cmp_consts.vh"
module i2cmp_filt (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Line
   input wire raw_i,
   output reg filt_q
);
   reg s1_q;
   reg s2_q;
   reg [2:0] cnt_q;

   always @(posedge core_clk) begin
      if (rst) begin
         s1_q <= `I2CMP_LINE_IDLE;
         s2_q <= `I2CMP_LINE_IDLE;
         cnt_q <= 3'h0;
         filt_q <= `I2CMP_LINE_IDLE;
      end else begin
         s1_q <= raw_i;
         s2_q <= s1_q;
         if (s2_q == filt_q) begin
            cnt_q <= 3'h0;
         end else if (cnt_q == `I2CMP_GLITCH_CYC - 3'h1) begin
            cnt_q <= 3'h0;
            filt_q <= s2_q;
         end else begin
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end
endmodule

// ==== i2cmp_top.v ====
// One two-wire port engine and the six-port controller that holds them.
`timescale 1ns/10ps
`include "i2cmp_consts.vh"
module i2cmp_port #(
   parameter HAS_SLAVE = 1
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Bus pins, open drain
   input wire scl_i,
   output wire scl_o,
   output wire scl_oe,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe,
   // Master control
   input wire [`I2CMP_DIV_W-1:0] clk_div,
   input wire [7:0] master_tx_byte,
   input wire mtx_start,
   input wire mtx_stop,
   input wire mtx_wr,
   input wire m_rx_nak,
   // Master status
   output reg [7:0] m_rx_byte,
   output reg m_done,
   output wire m_busy,
   output reg m_nak,
   output reg m_ten_bit,
   output reg m_rd,
   output reg m_arb_lost,
   output reg bus_busy,
   // Slave section
   input wire [`I2CMP_SADDR_W-1:0] s_addr,
   input wire [`I2CMP_NSADDR-1:0] s_addr_en,
   input wire [7:0] stx_byte,
   input wire stx_wr,
   output wire [7:0] srx_byte,
   output wire srx_valid,
   output wire stx_req,
   output wire s_active
);
   localparam M_IDLE = 6'h01;
   localparam M_START = 6'h02;
   localparam M_LOW = 6'h04;
   localparam M_HIGH = 6'h08;
   localparam M_HOLD = 6'h10;
   localparam M_STOP = 6'h20;

   wire scl_f;
   wire sda_f;
   reg scl_p_q;
   reg sda_p_q;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire ssda_oe;

   reg [5:0] ms_q;
   reg [`I2CMP_DIV_W-1:0] cnt_q;
   reg [1:0] step_q;
   reg [3:0] bit_q;
   reg [7:0] txb_q;
   reg adr_q;
   reg stop_pend_q;
   reg mscl_oe_q;
   reg msda_oe_q;
   wire tick;
   wire rx_data;
   wire accept;
   wire drive_low;

   i2cmp_filt u_scl (
      .core_clk(core_clk),
      .rst(rst),
      .raw_i(scl_i),
      .filt_q(scl_f)
   );
   i2cmp_filt u_sda (
      .core_clk(core_clk),
      .rst(rst),
      .raw_i(sda_i),
      .filt_q(sda_f)
   );

   assign scl_rise = scl_f & ~scl_p_q;
   assign scl_fall = ~scl_f & scl_p_q;
   assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
   assign stop_det = scl_f & scl_p_q & ~sda_p_q & sda_f;

   // Both ends only ever pull low; the pin output level is fixed.
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = mscl_oe_q;
   assign sda_oe = msda_oe_q | ssda_oe;
   assign m_busy = (ms_q != M_IDLE);

   assign tick = (cnt_q == clk_div);
   // Reading data bytes after the address byte leaves the data line to the slave.
   assign rx_data = m_rd & ~adr_q;
   // start from idle only on a free bus; in hold any write is taken, a repeated start included
   assign accept = mtx_wr & (((ms_q == M_IDLE) & ~bus_busy & mtx_start) | (ms_q == M_HOLD));
   assign drive_low = (bit_q == `I2CMP_ACK_BIT) ? (rx_data & ~m_rx_nak) : (~rx_data & ~txb_q[7]);

   always @(posedge core_clk) begin
      if (rst) begin
         scl_p_q <= `I2CMP_LINE_IDLE;
         sda_p_q <= `I2CMP_LINE_IDLE;
         bus_busy <= 1'b0;
      end else begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
         if (start_det) begin
            bus_busy <= 1'b1;
         end else if (stop_det) begin
            bus_busy <= 1'b0;
         end
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         cnt_q <= {`I2CMP_DIV_W{1'b0}};
      end else if ((ms_q == M_IDLE) | (ms_q == M_HOLD) | tick | ((ms_q == M_HIGH) & ~scl_f)) begin
         cnt_q <= {`I2CMP_DIV_W{1'b0}};
      end else begin
         cnt_q <= cnt_q + {{(`I2CMP_DIV_W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge core_clk) begin
      if (rst) begin
         ms_q <= M_IDLE;
         step_q <= `I2CMP_STEP_0;
         bit_q <= `I2CMP_BIT_FIRST;
         txb_q <= 8'h00;
         adr_q <= 1'b0;
         stop_pend_q <= 1'b0;
         mscl_oe_q <= 1'b0;
         msda_oe_q <= 1'b0;
         m_rx_byte <= 8'h00;
         m_done <= 1'b0;
         m_nak <= 1'b0;
         m_ten_bit <= 1'b0;
         m_rd <= 1'b0;
         m_arb_lost <= 1'b0;
      end else begin
         m_done <= 1'b0;
         if (accept) begin
            txb_q <= master_tx_byte;
            stop_pend_q <= mtx_stop;
            step_q <= `I2CMP_STEP_0;
            bit_q <= `I2CMP_BIT_FIRST;
            adr_q <= mtx_start;
            if (mtx_start) begin
               m_rd <= master_tx_byte[`I2CMP_DIR_BIT];
               m_ten_bit <= (master_tx_byte[7:3] == `I2CMP_TEN_PFX);
               m_arb_lost <= 1'b0;
               ms_q <= M_START;
            end else begin
               ms_q <= M_LOW;
            end
         end else begin
            case (ms_q)
               M_IDLE: begin
                  mscl_oe_q <= 1'b0;
                  msda_oe_q <= 1'b0;
               end
               M_START: begin
                  if (tick) begin
                     step_q <= step_q + 2'h1;
                     if (step_q == `I2CMP_STEP_0) begin
                        msda_oe_q <= 1'b0;
                     end else if (step_q == `I2CMP_STEP_1) begin
                        mscl_oe_q <= 1'b0;
                     end else if (step_q == `I2CMP_STEP_2) begin
                        msda_oe_q <= 1'b1;
                     end else begin
                        mscl_oe_q <= 1'b1;
                        ms_q <= M_LOW;
                     end
                  end
               end
               M_LOW: begin
                  // Data moves only in the first half of the low phase, so it never changes with the clock high.
                  if (tick) begin
                     if (step_q == `I2CMP_STEP_0) begin
                        msda_oe_q <= drive_low;
                        step_q <= `I2CMP_STEP_1;
                     end else begin
                        mscl_oe_q <= 1'b0;
                        step_q <= `I2CMP_STEP_0;
                        ms_q <= M_HIGH;
                     end
                  end
               end
               M_HIGH: begin
                  if (tick) begin
                     mscl_oe_q <= 1'b1;
                     bit_q <= bit_q - 4'h1;
                     if (bit_q == `I2CMP_ACK_BIT) begin
                        if (~rx_data) begin
                           m_nak <= sda_f;
                        end
                        m_done <= 1'b1;
                        adr_q <= 1'b0;
                        ms_q <= stop_pend_q ? M_STOP : M_HOLD;
                     end else if (~rx_data & ~msda_oe_q & ~sda_f) begin
                        // Another master pulled data low; back off and leave the bus alone.
                        m_arb_lost <= 1'b1;
                        mscl_oe_q <= 1'b0;
                        ms_q <= M_IDLE;
                     end else begin
                        m_rx_byte <= {m_rx_byte[6:0], sda_f};
                        txb_q <= {txb_q[6:0], 1'b0};
                        ms_q <= M_LOW;
                     end
                  end
               end
               M_HOLD: begin
                  // The clock is held low until firmware supplies the next byte.
                  mscl_oe_q <= 1'b1;
               end
               M_STOP: begin
                  if (tick) begin
                     step_q <= step_q + 2'h1;
                     if (step_q == `I2CMP_STEP_0) begin
                        msda_oe_q <= 1'b1;
                     end else if (step_q == `I2CMP_STEP_1) begin
                        mscl_oe_q <= 1'b0;
                     end else begin
                        msda_oe_q <= 1'b0;
                        step_q <= `I2CMP_STEP_0;
                        ms_q <= M_IDLE;
                     end
                  end
               end
               default: begin
                  ms_q <= M_IDLE;
               end
            endcase
         end
      end
   end

   generate
      if (HAS_SLAVE != 0) begin : g_slave
         localparam S_IDLE = 4'h1;
         localparam S_ADDR = 4'h2;
         localparam S_RX = 4'h4;
         localparam S_TX = 4'h8;
         reg [3:0] ss_q;
         reg [3:0] scnt_q;
         reg [7:0] ssh_q;
         reg [7:0] stx_q;
         reg [7:0] srx_q;
         reg sack_q;
         reg smnak_q;
         reg ssda_q;
         reg srx_v_q;
         reg stx_req_q;
         wire hit;

         function slot_hit;
            input [`I2CMP_ADDR_W-1:0] want;
            input [`I2CMP_ADDR_W-1:0] got;
            input en;
            begin
               slot_hit = en & (want == got);
            end
         endfunction

         assign hit = slot_hit(s_addr[6:0], ssh_q[7:1], s_addr_en[0]) |
                      slot_hit(s_addr[13:7], ssh_q[7:1], s_addr_en[1]) |
                      slot_hit(s_addr[20:14], ssh_q[7:1], s_addr_en[2]);
         assign ssda_oe = ssda_q;
         assign srx_byte = srx_q;
         assign srx_valid = srx_v_q;
         assign stx_req = stx_req_q;
         assign s_active = (ss_q != S_IDLE);

         always @(posedge core_clk) begin
            if (rst) begin
               ss_q <= S_IDLE;
               scnt_q <= 4'h0;
               ssh_q <= 8'h00;
               stx_q <= 8'h00;
               srx_q <= 8'h00;
               sack_q <= 1'b0;
               smnak_q <= 1'b0;
               ssda_q <= 1'b0;
               srx_v_q <= 1'b0;
               stx_req_q <= 1'b0;
            end else begin
               srx_v_q <= 1'b0;
               stx_req_q <= 1'b0;
               if (stx_wr) begin
                  stx_q <= stx_byte;
               end
               if (start_det) begin
                  ss_q <= S_ADDR;
                  scnt_q <= 4'h0;
                  sack_q <= 1'b0;
                  ssda_q <= 1'b0;
               end else if (stop_det) begin
                  ss_q <= S_IDLE;
                  sack_q <= 1'b0;
                  ssda_q <= 1'b0;
               end else if (ss_q != S_IDLE) begin
                  if (scl_rise) begin
                     if (sack_q) begin
                        smnak_q <= sda_f;
                     end else if (scnt_q != `I2CMP_SCNT_FULL) begin
                        ssh_q <= {ssh_q[6:0], sda_f};
                        scnt_q <= scnt_q + 4'h1;
                     end
                  end else if (scl_fall) begin
                     if (sack_q) begin
                        sack_q <= 1'b0;
                        scnt_q <= 4'h0;
                        ssda_q <= 1'b0;
                        if (ss_q == S_TX) begin
                           // A not-acknowledge from the reader ends our sending.
                           if (smnak_q) begin
                              ss_q <= S_IDLE;
                           end else begin
                              ssh_q <= stx_q;
                              ssda_q <= ~stx_q[7];
                              stx_req_q <= 1'b1;
                           end
                        end
                     end else if (scnt_q == `I2CMP_SCNT_FULL) begin
                        sack_q <= 1'b1;
                        case (ss_q)
                           S_ADDR: begin
                              ssda_q <= hit;
                              smnak_q <= 1'b0;
                              ss_q <= hit ? (ssh_q[`I2CMP_DIR_BIT] ? S_TX : S_RX) : S_IDLE;
                           end
                           S_RX: begin
                              ssda_q <= 1'b1;
                              srx_q <= ssh_q;
                              srx_v_q <= 1'b1;
                           end
                           default: begin
                              ssda_q <= 1'b0;
                           end
                        endcase
                     end else if (ss_q == S_TX) begin
                        ssda_q <= ~ssh_q[7];
                     end
                  end
               end
            end
         end
      end else begin : g_noslave
         assign ssda_oe = 1'b0;
         assign srx_byte = 8'h00;
         assign srx_valid = 1'b0;
         assign stx_req = 1'b0;
         assign s_active = 1'b0;
      end
   endgenerate
endmodule

module i2cmp_top (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Bus pins, one bit per port
   input wire [`I2CMP_NPORTS-1:0] scl_i,
   output wire [`I2CMP_NPORTS-1:0] scl_o,
   output wire [`I2CMP_NPORTS-1:0] scl_oe,
   input wire [`I2CMP_NPORTS-1:0] sda_i,
   output wire [`I2CMP_NPORTS-1:0] sda_o,
   output wire [`I2CMP_NPORTS-1:0] sda_oe,
   // Master control, per port
   input wire [`I2CMP_NPORTS*`I2CMP_DIV_W-1:0] clk_div,
   input wire [`I2CMP_NPORTS*8-1:0] master_tx_byte,
   input wire [`I2CMP_NPORTS-1:0] mtx_start,
   input wire [`I2CMP_NPORTS-1:0] mtx_stop,
   input wire [`I2CMP_NPORTS-1:0] mtx_wr,
   input wire [`I2CMP_NPORTS-1:0] m_rx_nak,
   // Master status, per port
   output wire [`I2CMP_NPORTS*8-1:0] m_rx_byte,
   output wire [`I2CMP_NPORTS-1:0] m_done,
   output wire [`I2CMP_NPORTS-1:0] m_busy,
   output wire [`I2CMP_NPORTS-1:0] m_nak,
   output wire [`I2CMP_NPORTS-1:0] m_ten_bit,
   output wire [`I2CMP_NPORTS-1:0] m_rd,
   output wire [`I2CMP_NPORTS-1:0] m_arb_lost,
   output wire [`I2CMP_NPORTS-1:0] bus_busy,
   // Slave sections, ports 0 and 1 only
   input wire [`I2CMP_MS_PORTS*`I2CMP_SADDR_W-1:0] s_addr,
   input wire [`I2CMP_MS_PORTS*`I2CMP_NSADDR-1:0] s_addr_en,
   input wire [`I2CMP_MS_PORTS*8-1:0] stx_byte,
   input wire [`I2CMP_MS_PORTS-1:0] stx_wr,
   output wire [`I2CMP_MS_PORTS*8-1:0] srx_byte,
   output wire [`I2CMP_MS_PORTS-1:0] srx_valid,
   output wire [`I2CMP_MS_PORTS-1:0] stx_req,
   output wire [`I2CMP_MS_PORTS-1:0] s_active
);
   genvar g;
   generate
      for (g = 0; g < `I2CMP_NPORTS; g = g + 1) begin : g_port
         localparam HS = (g < `I2CMP_MS_PORTS) ? 1 : 0;
         localparam SI = (g < `I2CMP_MS_PORTS) ? g : 0;
         wire [7:0] srx_w;
         wire srx_v_w;
         wire stx_req_w;
         wire sact_w;
         i2cmp_port #(.HAS_SLAVE(HS)) u_port (
            .core_clk(core_clk),
            .rst(rst),
            .scl_i(scl_i[g]),
            .scl_o(scl_o[g]),
            .scl_oe(scl_oe[g]),
            .sda_i(sda_i[g]),
            .sda_o(sda_o[g]),
            .sda_oe(sda_oe[g]),
            .clk_div(clk_div[g*`I2CMP_DIV_W +: `I2CMP_DIV_W]),
            .master_tx_byte(master_tx_byte[g*8 +: 8]),
            .mtx_start(mtx_start[g]),
            .mtx_stop(mtx_stop[g]),
            .mtx_wr(mtx_wr[g]),
            .m_rx_nak(m_rx_nak[g]),
            .m_rx_byte(m_rx_byte[g*8 +: 8]),
            .m_done(m_done[g]),
            .m_busy(m_busy[g]),
            .m_nak(m_nak[g]),
            .m_ten_bit(m_ten_bit[g]),
            .m_rd(m_rd[g]),
            .m_arb_lost(m_arb_lost[g]),
            .bus_busy(bus_busy[g]),
            .s_addr(s_addr[SI*`I2CMP_SADDR_W +: `I2CMP_SADDR_W]),
            .s_addr_en(HS ? s_addr_en[SI*`I2CMP_NSADDR +: `I2CMP_NSADDR] : {`I2CMP_NSADDR{1'b0}}),
            .stx_byte(stx_byte[SI*8 +: 8]),
            .stx_wr(HS ? stx_wr[SI] : 1'b0),
            .srx_byte(srx_w),
            .srx_valid(srx_v_w),
            .stx_req(stx_req_w),
            .s_active(sact_w)
         );
         if (g < `I2CMP_MS_PORTS) begin : g_sout
            assign srx_byte[g*8 +: 8] = srx_w;
            assign srx_valid[g] = srx_v_w;
            assign stx_req[g] = stx_req_w;
            assign s_active[g] = sact_w;
         end
      end
   endgenerate
endmodule

// ==== i2cmp_assertions.sv ====
// Port-level assertions for the six-port two-wire controller.
`timescale 1ns/10ps
module i2cmp_checker (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Bus pins
   input wire [5:0] scl_o,
   input wire [5:0] scl_oe,
   input wire [5:0] sda_o,
   input wire [5:0] sda_oe,
   // Master control and status
   input wire [5:0] mtx_start,
   input wire [5:0] mtx_wr,
   input wire [5:0] m_done,
   input wire [5:0] m_busy,
   input wire [5:0] bus_busy,
   // Slave status
   input wire [1:0] srx_valid,
   input wire [1:0] stx_req
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_open_drain: assert property (scl_o == 6'h00 && sda_o == 6'h00)
      else $error("bus pin driven high");
   a_master_clock: assert property ((scl_oe & ~(m_busy | $past(m_busy))) == 6'h00)
      else $error("clock pulled without master activity");
   a_no_slave_data: assert property ((sda_oe[5:2] & ~(m_busy[5:2] | $past(m_busy[5:2]))) == 4'h0)
      else $error("master-only port drives data while idle");
   a_done_single: assert property ((m_done & $past(m_done)) == 6'h00)
      else $error("byte done lasts over one cycle");
   a_done_busy: assert property ((m_done & ~m_busy) == 6'h00)
      else $error("byte done while engine idle");
   a_idle_refuse: assert property (mtx_wr[0] && !mtx_start[0] && !m_busy[0] |=> !m_busy[0])
      else $error("write without start accepted at idle");
   a_start_taken: assert property (mtx_wr[0] && mtx_start[0] && !m_busy[0] && !bus_busy[0] |=> m_busy[0])
      else $error("start write not accepted");
   a_start_seen: assert property ($rose(m_busy[0]) |-> ##[1:300] bus_busy[0])
      else $error("start never seen on the bus");
   a_slave_pulses: assert property ((srx_valid & $past(srx_valid)) == 2'h0 && (stx_req & $past(stx_req)) == 2'h0)
      else $error("slave pulse lasts over one cycle");
endmodule
bind i2cmp_top i2cmp_checker chk (.core_clk(core_clk), .rst(rst), .scl_o(scl_o), .scl_oe(scl_oe),
   .sda_o(sda_o), .sda_oe(sda_oe), .mtx_start(mtx_start), .mtx_wr(mtx_wr), .m_done(m_done),
   .m_busy(m_busy), .bus_busy(bus_busy), .srx_valid(srx_valid), .stx_req(stx_req));

// ==== i2cmp_slave_model.sv ====
// Behavioural two-wire slave device sitting on a master port.
`timescale 1ns/10ps
module i2cmp_slave_model #(
   parameter [6:0] DEV_ADDR = 7'h2c
) (
   // Clock
   input wire core_clk,
   // Resolved line levels and pulls
   input wire scl_w,
   input wire sda_w,
   output wire scl_pull,
   output wire sda_pull,
   // Scenario controls
   input wire nak_d,
   input wire [7:0] rd_byte,
   input wire [3:0] stretch
);
   reg scl_p = 1'h1;
   reg sda_p = 1'h1;
   reg act = 1'h0;
   reg first = 1'h0;
   reg hit = 1'h0;
   reg rdm = 1'h0;
   reg pull = 1'h0;
   reg [3:0] bitc = 4'h0;
   reg [3:0] hold = 4'h0;
   reg [7:0] sh = 8'h00;
   reg [7:0] tx = 8'h00;
   assign sda_pull = pull;
   assign scl_pull = hold != 4'h0;
   always @(posedge core_clk) begin
      scl_p <= scl_w;
      sda_p <= sda_w;
      if (hold != 4'h0) begin
         hold <= hold - 4'h1;
      end
      if (scl_w && scl_p && sda_p && !sda_w) begin
         act <= 1'h1;
         first <= 1'h1;
         bitc <= 4'h0;
      end else if (scl_w && scl_p && !sda_p && sda_w) begin
         act <= 1'h0;
         pull <= 1'h0;
      end else if (act && scl_w && !scl_p) begin
         sh <= {sh[6:0], sda_w};
         bitc <= bitc + 4'h1;
         if (bitc == 4'h8 && !first && sda_w) begin
            rdm <= 1'h0;
         end
      end else if (act && !scl_w && scl_p) begin
         if (bitc == 4'h8 && first) begin
            hit <= sh[7:1] == DEV_ADDR;
            rdm <= sh[0] && sh[7:1] == DEV_ADDR;
            pull <= sh[7:1] == DEV_ADDR;
         end else if (bitc == 4'h8) begin
            pull <= hit && !rdm && !nak_d;
         end else if (bitc == 4'h9) begin
            first <= 1'h0;
            bitc <= 4'h0;
            hold <= stretch;
            tx <= rd_byte;
            pull <= rdm && !rd_byte[7];
         end else if (rdm && !first) begin
            pull <= !tx[3'h7 - bitc[2:0]];
         end
      end
   end
endmodule

// ==== i2cmp_top_bench.sv ====
// Self-checking bench for the six-port two-wire controller.
`timescale 1ns/10ps
`define CHK(g, e) begin \
   tests_run = tests_run + 1; \
   if ((g) !== (e)) begin \
      errors = errors + 1; \
      $display("mismatch at %0t got %h exp %h", $time, g, e); \
   end \
end
module i2cmp_top_bench;
   reg core_clk = 1'h0;
   reg rst = 1'h1;
   reg [5:0] mtx_start = 6'h00;
   reg [5:0] mtx_stop = 6'h00;
   reg [5:0] mtx_wr = 6'h00;
   reg [5:0] m_rx_nak = 6'h00;
   reg [95:0] clk_div = {6{16'h0002}};
   reg [47:0] master_tx_byte = 48'h0;
   reg [41:0] s_addr = 42'h0;
   reg [5:0] s_addr_en = 6'h1b;
   reg [15:0] stx_byte = 16'h0;
   reg [1:0] stx_wr = 2'h0;
   reg bm_scl = 1'h1;
   reg bm_sda = 1'h1;
   reg gl = 1'h0;
   reg nak_d = 1'h0;
   reg [7:0] rd_byte = 8'h00;
   reg [3:0] stretch = 4'h0;
   reg [31:0] seed = 32'h5fa2f6db;
   reg [5:0] scl_p = 6'h3f;
   reg [7:0] rx;
   reg ak;
   integer errors = 0;
   integer tests_run = 0;
   integer cur = 0;
   integer rises = 0;
   integer cyc = 0;
   integer r0, c0, nb, cb, n, p, k;
   wire [5:0] scl_o, scl_oe, sda_o, sda_oe, m_done, m_busy, m_nak, m_ten_bit, m_rd, bus_busy, mscl, msda;
   wire [47:0] m_rx_byte;
   wire [15:0] srx_byte;
   wire [1:0] srx_valid, stx_req, s_active;
   // Port 1 faces the bench as bus master; the others face slave models.
   wire [5:0] scl_w = ~(scl_oe | mscl) & {4'hf, bm_scl, 1'h1};
   wire [5:0] sda_w = ~(sda_oe | msda) & {~gl, 3'h7, bm_sda, 1'h1};
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      scl_p <= scl_w;
      cyc <= cyc + 1;
      if (scl_w[cur] && !scl_p[cur]) begin
         rises <= rises + 1;
      end
   end
   i2cmp_top dut (.core_clk(core_clk), .rst(rst), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .clk_div(clk_div), .master_tx_byte(master_tx_byte),
      .mtx_start(mtx_start), .mtx_stop(mtx_stop), .mtx_wr(mtx_wr), .m_rx_nak(m_rx_nak), .m_rx_byte(m_rx_byte),
      .m_done(m_done), .m_busy(m_busy), .m_nak(m_nak), .m_ten_bit(m_ten_bit), .m_rd(m_rd), .m_arb_lost(),
      .bus_busy(bus_busy), .s_addr(s_addr), .s_addr_en(s_addr_en), .stx_byte(stx_byte), .stx_wr(stx_wr),
      .srx_byte(srx_byte), .srx_valid(srx_valid), .stx_req(stx_req), .s_active(s_active));
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : far
         if (g == 1) begin : none
            assign mscl[g] = 1'h0;
            assign msda[g] = 1'h0;
         end else begin : dev
            i2cmp_slave_model model (.core_clk(core_clk), .scl_w(scl_w[g]), .sda_w(sda_w[g]), .scl_pull(mscl[g]),
               .sda_pull(msda[g]), .nak_d(nak_d), .rd_byte(rd_byte), .stretch(stretch));
         end
      end
   endgenerate
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function integer min_cyc(input integer d);
      min_cyc = 27 * (d + 1);
   endfunction
   task tick(input integer t);
      repeat (t) @(posedge core_clk);
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", tests_run, errors);
         if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
         end else begin
            $display("TESTS FAILED");
         end
         $finish;
      end
   endtask
   // Bounded wait for byte done, or for the engine to fall idle.
   task wait_on(input idle);
      begin
         n = 0;
         while ((idle ? m_busy[cur] : !m_done[cur]) && n < 9000) begin
            @(posedge core_clk);
            #1 n = n + 1;
         end
         if (n == 9000) begin
            errors = errors + 1;
            close_out;
         end
      end
   endtask
   task mbyte(input [7:0] b, input st, input sp, input nk);
      begin
         @(posedge core_clk);
         master_tx_byte[cur*8 +: 8] <= b;
         mtx_start[cur] <= st;
         mtx_stop[cur] <= sp;
         m_rx_nak[cur] <= nk;
         mtx_wr[cur] <= 1'h1;
         @(posedge core_clk);
         mtx_wr[cur] <= 1'h0;
         #1 r0 = rises;
         c0 = cyc;
         wait_on(1'h0);
         nb = rises - r0;
         cb = cyc - c0;
         if (sp) begin
            wait_on(1'h1);
            tick(12);
         end
      end
   endtask
   // One bench-mastered bit, five cycles high; the low phase outlasts the filtered slave reply so data never moves under a high clock.
   task sbit(input b);
      begin
         @(posedge core_clk);
         bm_sda <= b;
         tick(8);
         bm_scl <= 1'h1;
         tick(5);
         bm_scl <= 1'h0;
         @(posedge core_clk);
         #1 ak = sda_w[1];
      end
   endtask
   task sbyte(input [7:0] b, input last);
      begin
         for (k = 7; k >= 0; k = k - 1) begin
            sbit(b[k]);
            rx[k] = ak;
         end
         sbit(last);
      end
   endtask
   task sframe(input st);
      begin
         @(posedge core_clk);
         bm_sda <= 1'h0;
         tick(6);
         bm_scl <= !st;
         tick(6);
         bm_sda <= 1'h1;
         tick(8);
      end
   endtask
   initial begin
      tick(16);
      rst <= 1'h0;
      tick(8);
      mtx_wr[0] <= 1'h1;
      @(posedge core_clk);
      mtx_wr[0] <= 1'h0;
      tick(3);
      #1 `CHK(m_busy[0], 1'h0)
      @(posedge core_clk);
      gl <= 1'h1;
      tick(3);
      gl <= 1'h0;
      tick(12);
      #1 `CHK(bus_busy[5], 1'h0)
      @(posedge core_clk);
      gl <= 1'h1;
      tick(12);
      #1 `CHK(bus_busy[5], 1'h1)
      @(posedge core_clk);
      gl <= 1'h0;
      tick(12);
      #1 `CHK(bus_busy[5], 1'h0)
      $display("test filter done");
      for (p = 0; p < 6; p = p + 1) begin
         if (p != 1) begin
            cur = p;
            seed = lfsr(seed);
            clk_div[p*16 +: 16] <= 16'h0002 + seed[1:0];
            nak_d <= seed[8];
            rd_byte <= seed[23:16];
            stretch <= {1'h0, seed[26:24]};
            mbyte({7'h2c, 1'h0}, 1'h1, 1'h0, 1'h0);
            `CHK(m_rd[p], 1'h0)
            `CHK(m_ten_bit[p], 1'h0)
            `CHK(m_nak[p], 1'h0)
            mbyte(seed[15:8], 1'h0, 1'h0, 1'h0);
            `CHK(m_nak[p], seed[8])
            `CHK(nb, 9)
            `CHK(cb >= min_cyc(2 + seed[1:0]), 1'h1)
            mbyte({7'h2c, 1'h1}, 1'h1, 1'h0, 1'h0);
            `CHK(m_rd[p], 1'h1)
            mbyte(8'hff, 1'h0, 1'h1, 1'h1);
            `CHK(m_rx_byte[p*8 +: 8], seed[23:16])
            mbyte({7'h2d, 1'h0}, 1'h1, 1'h1, 1'h0);
            `CHK(m_nak[p], 1'h1)
            mbyte(8'hf6, 1'h1, 1'h1, 1'h0);
            `CHK(m_ten_bit[p], 1'h1)
            $display("test master port %0d done", p);
         end
      end
      cur = 1;
      s_addr[41:21] <= {7'h51, 7'h3a, 7'h15};
      stx_byte[15:8] <= seed[31:24];
      stx_wr[1] <= 1'h1;
      @(posedge core_clk);
      stx_wr[1] <= 1'h0;
      for (p = 0; p < 3; p = p + 1) begin
         sframe(1'h1);
         sbyte({s_addr[21 + p*7 +: 7], 1'h0}, 1'h1);
         `CHK(ak, p == 2)
         sbyte(seed[7:0] ^ p[7:0], 1'h1);
         if (p < 2) begin
            `CHK(srx_byte[15:8], seed[7:0] ^ p[7:0])
         end
         sframe(1'h0);
      end
      sframe(1'h1);
      sbyte({7'h3a, 1'h1}, 1'h1);
      `CHK(ak, 1'h0)
      sbyte(8'hff, 1'h1);
      `CHK(rx, seed[31:24])
      sframe(1'h0);
      $display("test slave port done");
      close_out;
   end
endmodule
